// [core/serial_bit_engine.sv]
// serial programming link: shared constants and the bit-level line engine
// assumes one system clock; an external pull-up holds the data line high
// How it works
// - data bytes travel least significant bit first, eight bits each
// - pages hold 128 bytes; a page write carries exactly 128 bytes unless the memory refuses a byte
// - write: start, device byte (select 0), three address bytes, data, stop
// - poll: start plus device byte; on refusal restart without stop
// - waiting out the write cycle keeps mode select low; clock and data keep toggling to poll
// - reads use device byte with select 1; current, random and sequential
// - current read: device byte, one byte out, then stop
// - random read: write header plus address, repeated start, read byte, stop
// - sequential read continues while acknowledged; last byte refused then stop
// - all programming happens only while mode select is held low
// - start is data falling under high clock, stop is data rising
// - receiver acknowledges by pulling data low, refuses by releasing it
// - device and address bytes travel most significant bit first
// - unused address bits are sent as given in cmd_addr, not forced to zero
package isp_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCL_PERIOD_NS = 400;
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [17:0] PAGE_BYTES = 18'h00080;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [7:0] POLL_MAX = 8'hFF;
	localparam logic [1:0] K_START = 2'h0;
	localparam logic [1:0] K_STOP = 2'h1;
	localparam logic [1:0] K_BIT = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ_CUR = 2'h1;
	localparam logic [1:0] OP_READ_RAND = 2'h2;
endpackage : isp_pkg

`timescale 1ns/10ps
module serial_bit_engine #(
	parameter int QTR = isp_pkg::QTR_CYC
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic sda_pin, // data line level from the pin
	input wire logic sym_go, // start one symbol
	input wire logic [1:0] sym_kind, // start, stop or bit
	input wire logic sym_bit, // bit to send, 1 releases
	output logic sym_done, // symbol finished, one cycle
	output logic sym_rx, // line level sampled at clock high
	output logic scl_q, // serial clock drive
	output logic sda_oe_n_q // low while pulling data low
);
	import isp_pkg::*;

	logic busy_q, busy_d, kind_bit_q;
	logic [1:0] kind_q, kind_d, ph_q, ph_d;
	logic bit_q, bit_d, done_d, rx_d, scl_d, oe_n_d;
	logic [7:0] cnt_q, cnt_d;
	logic sda_meta_q, sda_sync_q;

	// two stages before any logic looks at the pin
	always_ff @(posedge clk_sys) begin
		sda_meta_q <= sda_pin;
		sda_sync_q <= sda_meta_q;
	end

	// four quarter phases per symbol; inside a bit data only moves while clock is low, start and stop move it under high clock
	always_comb begin
		busy_d = busy_q;
		kind_d = kind_q;
		bit_d = bit_q;
		ph_d = ph_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		rx_d = sym_rx;
		scl_d = scl_q;
		oe_n_d = sda_oe_n_q;
		if (!busy_q) begin
			if (sym_go) begin
				busy_d = 1'b1;
				kind_d = sym_kind;
				bit_d = sym_bit;
				ph_d = 2'h0;
				cnt_d = 8'h00;
			end
		end else if (cnt_q == 8'(QTR - 1)) begin
			cnt_d = 8'h00;
			ph_d = ph_q + 2'h1;
			if (ph_q == 2'h2 && kind_q == K_BIT) begin
				rx_d = sda_sync_q;
			end
			if (ph_q == 2'h3) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
		if (busy_d) begin
			case (kind_d)
				K_START: begin
					scl_d = (ph_d == 2'h1) || (ph_d == 2'h2);
					oe_n_d = (ph_d == 2'h0) || (ph_d == 2'h1);
				end
				K_STOP: begin
					scl_d = (ph_d != 2'h0);
					oe_n_d = (ph_d == 2'h2) || (ph_d == 2'h3);
				end
				default: begin
					scl_d = (ph_d == 2'h1) || (ph_d == 2'h2);
					oe_n_d = bit_d;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			kind_q <= K_STOP;
			bit_q <= 1'b1;
			ph_q <= 2'h0;
			cnt_q <= 8'h00;
			sym_done <= 1'b0;
			sym_rx <= 1'b1;
			scl_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else begin
			busy_q <= busy_d;
			kind_q <= kind_d;
			bit_q <= bit_d;
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			sym_done <= done_d;
			sym_rx <= rx_d;
			scl_q <= scl_d;
			sda_oe_n_q <= oe_n_d;
		end
	end

	assign kind_bit_q = busy_q && kind_q == K_BIT;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	AST_BIT_STEADY_HIGH: assert property (
		(kind_bit_q && scl_q && $past(scl_q)) |-> $stable(sda_oe_n_q))
		else $error("data moved while clock high inside a bit");
	AST_FALL_ONLY_START: assert property (
		(scl_q && $past(scl_q) && $fell(sda_oe_n_q)) |-> kind_q == K_START)
		else $error("data pulled low under high clock outside start");
	AST_RISE_ONLY_STOP: assert property (
		(scl_q && $past(scl_q) && $rose(sda_oe_n_q)) |-> kind_q == K_STOP)
		else $error("data released under high clock outside stop");
endmodule : serial_bit_engine

// [core/isp_programmer.sv]
// host-side programmer for the serial configuration memory port
// assumes serial_bit_engine and isp_pkg compiled first; data line pulled up
`timescale 1ns/10ps
module isp_programmer #(
	parameter logic [6:0] DEV_ID7 = 7'h2A // device address, arbitrary
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic program_enable, // request programming mode
	input wire logic cmd_valid, // command offered
	output logic cmd_ready, // command accepted when both high
	input wire logic [1:0] cmd_op, // isp_pkg::OP_* code
	input wire logic [23:0] cmd_addr, // start address (write, random read)
	input wire logic [17:0] cmd_len, // bytes to read, 0 means 1
	input wire logic [7:0] wr_data, // page byte to write
	input wire logic wr_valid, // page byte offered
	output logic wr_ready, // page byte taken when both high
	output logic [7:0] rd_data, // byte read back
	output logic rd_valid, // rd_data new, one cycle
	output logic done, // command finished, one cycle
	output logic error, // refusal seen, level until next command
	output logic serial_clock_line, // serial clock to the memory
	input wire logic serial_data_line_in, // data line level
	output logic serial_data_line_out, // data drive value, always low
	output logic serial_data_line_oe_n, // low while pulling data low
	output logic program_mode_select_n // low selects programming mode
);
	import isp_pkg::*;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01, S_START = 8'h02, S_TXBIT = 8'h04, S_RXACK = 8'h08,
		S_WLOAD = 8'h10, S_RXBIT = 8'h20, S_TXACK = 8'h40, S_STOP = 8'h80
	} state_e;
	typedef enum logic [1:0] {
		ROLE_DEV = 2'h0, ROLE_ADDR = 2'h1, ROLE_DATA = 2'h2
	} role_e;

	state_e state_q, state_d;
	role_e role_q, role_d;
	logic [1:0] op_q, op_d, idx_q, idx_d;
	logic [23:0] addr_q, addr_d;
	logic [17:0] len_q, len_d, count_q, count_d;
	logic [7:0] tx_q, tx_d, rx_q, rx_d, poll_q, poll_d, rdd_d;
	logic [2:0] bitcnt_q, bitcnt_d;
	logic rphase_q, rphase_d, go_q, go_d, sbit_q, sbit_d;
	logic [1:0] kind_q, kind_d;
	logic cmdr_d, wrr_d, rdv_d, done_d, err_d, pn_d, sdo_d;
	logic sym_done, sym_rx, ack, last_rd;

	serial_bit_engine #(.QTR(QTR_CYC)) u_eng (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.sda_pin(serial_data_line_in),
		.sym_go(go_q),
		.sym_kind(kind_q),
		.sym_bit(sbit_q),
		.sym_done(sym_done),
		.sym_rx(sym_rx),
		.scl_q(serial_clock_line),
		.sda_oe_n_q(serial_data_line_oe_n)
	);

	assign ack = !sym_rx;
	assign last_rd = (count_q == len_q - 18'h00001);

	// byte sequencer: one engine symbol in flight at a time
	always_comb begin
		state_d = state_q;
		role_d = role_q;
		op_d = op_q;
		idx_d = idx_q;
		addr_d = addr_q;
		len_d = len_q;
		count_d = count_q;
		tx_d = tx_q;
		rx_d = rx_q;
		poll_d = poll_q;
		bitcnt_d = bitcnt_q;
		rphase_d = rphase_q;
		go_d = 1'b0;
		kind_d = kind_q;
		sbit_d = sbit_q;
		cmdr_d = 1'b0;
		wrr_d = 1'b0;
		rdv_d = 1'b0;
		rdd_d = rd_data;
		done_d = 1'b0;
		err_d = error;
		pn_d = program_mode_select_n;
		sdo_d = 1'b0;
		case (state_q)
			S_IDLE: begin
				// mode select only moves between commands
				pn_d = !program_enable;
				cmdr_d = program_enable && !program_mode_select_n;
				if (cmd_valid && cmd_ready) begin
					cmdr_d = 1'b0;
					op_d = cmd_op;
					addr_d = cmd_addr;
					len_d = (cmd_len == 18'h00000) ? 18'h00001 : cmd_len;
					count_d = 18'h00000;
					poll_d = 8'h00;
					err_d = 1'b0;
					rphase_d = (cmd_op == OP_READ_CUR);
					state_d = S_START;
					go_d = 1'b1;
					kind_d = K_START;
				end
			end
			S_START: begin
				if (sym_done) begin
					role_d = ROLE_DEV;
					tx_d = {DEV_ID7, rphase_q};
					bitcnt_d = 3'h0;
					state_d = S_TXBIT;
					go_d = 1'b1;
					kind_d = K_BIT;
					sbit_d = DEV_ID7[6];
				end
			end
			S_TXBIT: begin
				if (sym_done) begin
					go_d = 1'b1;
					kind_d = K_BIT;
					if (bitcnt_q == 3'h7) begin
						state_d = S_RXACK;
						sbit_d = 1'b1;
					end else begin
						bitcnt_d = bitcnt_q + 3'h1;
						if (role_q == ROLE_DATA) begin
							tx_d = {1'b0, tx_q[7:1]};
							sbit_d = tx_q[1];
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							sbit_d = tx_q[6];
						end
					end
				end
			end
			S_RXACK: begin
				if (sym_done) begin
					go_d = 1'b1;
					if (!ack) begin
						if (role_q == ROLE_DEV && op_q == OP_WRITE &&
							poll_q != POLL_MAX) begin
							// memory busy writing: retry, no stop
							poll_d = poll_q + 8'h01;
							state_d = S_START;
							kind_d = K_START;
						end else begin
							err_d = 1'b1;
							state_d = S_STOP;
							kind_d = K_STOP;
						end
					end else begin
						case (role_q)
							ROLE_DEV: begin
								if (rphase_q) begin
									bitcnt_d = 3'h0;
									state_d = S_RXBIT;
									kind_d = K_BIT;
									sbit_d = 1'b1;
								end else begin
									role_d = ROLE_ADDR;
									idx_d = 2'h0;
									tx_d = addr_q[23:16];
									bitcnt_d = 3'h0;
									state_d = S_TXBIT;
									kind_d = K_BIT;
									sbit_d = addr_q[23];
								end
							end
							ROLE_ADDR: begin
								if (idx_q == ADDR_LAST) begin
									go_d = 1'b0;
									if (op_q == OP_WRITE) begin
										role_d = ROLE_DATA;
										state_d = S_WLOAD;
									end else begin
										// header only loaded the counter
										go_d = 1'b1;
										rphase_d = 1'b1;
										state_d = S_START;
										kind_d = K_START;
									end
								end else begin
									idx_d = idx_q + 2'h1;
									tx_d = (idx_q == 2'h0) ? addr_q[15:8]
										: addr_q[7:0];
									bitcnt_d = 3'h0;
									state_d = S_TXBIT;
									kind_d = K_BIT;
									sbit_d = tx_d[7];
								end
							end
							default: begin
								count_d = count_q + 18'h00001;
								if (count_q == PAGE_BYTES - 18'h00001) begin
									state_d = S_STOP;
									kind_d = K_STOP;
								end else begin
									go_d = 1'b0;
									state_d = S_WLOAD;
								end
							end
						endcase
					end
				end
			end
			S_WLOAD: begin
				// stalls the page until the user offers the next byte
				wrr_d = 1'b1;
				if (wr_ready && wr_valid) begin
					wrr_d = 1'b0;
					tx_d = wr_data;
					bitcnt_d = 3'h0;
					state_d = S_TXBIT;
					go_d = 1'b1;
					kind_d = K_BIT;
					sbit_d = wr_data[0];
				end
			end
			S_RXBIT: begin
				if (sym_done) begin
					go_d = 1'b1;
					kind_d = K_BIT;
					rx_d = {sym_rx, rx_q[7:1]};
					if (bitcnt_q == 3'h7) begin
						rdd_d = rx_d;
						rdv_d = 1'b1;
						count_d = count_q + 18'h00001;
						state_d = S_TXACK;
						sbit_d = last_rd;
					end else begin
						bitcnt_d = bitcnt_q + 3'h1;
						sbit_d = 1'b1;
					end
				end
			end
			S_TXACK: begin
				if (sym_done) begin
					go_d = 1'b1;
					if (sbit_q) begin
						state_d = S_STOP;
						kind_d = K_STOP;
					end else begin
						bitcnt_d = 3'h0;
						state_d = S_RXBIT;
						kind_d = K_BIT;
						sbit_d = 1'b1;
					end
				end
			end
			S_STOP: begin
				if (sym_done) begin
					done_d = 1'b1;
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
			role_q <= ROLE_DEV;
			op_q <= OP_WRITE;
			idx_q <= 2'h0;
			addr_q <= 24'h000000;
			len_q <= 18'h00001;
			count_q <= 18'h00000;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			poll_q <= 8'h00;
			bitcnt_q <= 3'h0;
			rphase_q <= 1'b0;
			go_q <= 1'b0;
			kind_q <= K_STOP;
			sbit_q <= 1'b1;
			cmd_ready <= 1'b0;
			wr_ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			done <= 1'b0;
			error <= 1'b0;
			program_mode_select_n <= 1'b1;
			serial_data_line_out <= 1'b0;
		end else begin
			state_q <= state_d;
			role_q <= role_d;
			op_q <= op_d;
			idx_q <= idx_d;
			addr_q <= addr_d;
			len_q <= len_d;
			count_q <= count_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			poll_q <= poll_d;
			bitcnt_q <= bitcnt_d;
			rphase_q <= rphase_d;
			go_q <= go_d;
			kind_q <= kind_d;
			sbit_q <= sbit_d;
			cmd_ready <= cmdr_d;
			wr_ready <= wrr_d;
			rd_valid <= rdv_d;
			rd_data <= rdd_d;
			done <= done_d;
			error <= err_d;
			program_mode_select_n <= pn_d;
			serial_data_line_out <= sdo_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	AST_MODE_HELD: assert property (
		(state_q != S_IDLE) |-> !program_mode_select_n)
		else $error("transaction running outside programming mode");
	AST_PAGE_EXACT: assert property (
		(state_q == S_RXACK && $past(state_q) == S_RXACK && state_d == S_STOP
		&& role_q == ROLE_DATA && !err_d) |-> count_q == PAGE_BYTES - 18'h1)
		else $error("page write stopped before 128 bytes");
	AST_POLL_NO_STOP: assert property (
		(state_q == S_RXACK && sym_done && !ack && role_q == ROLE_DEV &&
		op_q == OP_WRITE && poll_q != POLL_MAX) |=> state_q == S_START
		&& kind_q == K_START)
		else $error("refused poll did not restart directly");
	AST_ADDR_MSB: assert property (
		(state_q == S_RXACK && sym_done && ack && role_q == ROLE_DEV &&
		!rphase_q) |=> tx_q == addr_q[23:16] && sbit_q == addr_q[23])
		else $error("first address byte not sent high bit first");
	AST_DATA_LSB: assert property (
		(wr_ready && wr_valid && state_q == S_WLOAD) |=>
		tx_q == $past(wr_data) && sbit_q == $past(wr_data[0]))
		else $error("data byte not sent low bit first");
	AST_RAND_RESTART: assert property (
		(state_q == S_RXACK && sym_done && ack && role_q == ROLE_ADDR &&
		idx_q == ADDR_LAST && op_q == OP_READ_RAND) |=>
		state_q == S_START && rphase_q)
		else $error("random read missed its repeated start");
	AST_LAST_REFUSED: assert property (
		(state_q == S_RXBIT && sym_done && bitcnt_q == 3'h7) |=>
		state_q == S_TXACK && sbit_q == (count_q == len_q))
		else $error("read acknowledge wrong for byte position");
	AST_DONE_AFTER_STOP: assert property (
		(state_q == S_STOP && sym_done) |=> done ##1 !done)
		else $error("done not a single pulse after stop");

	COV_PAGE_WRITE: cover property (
		state_q == S_STOP && sym_done && op_q == OP_WRITE && !error);
	COV_POLL_RETRY: cover property (
		state_q == S_RXACK && sym_done && !ack && role_q == ROLE_DEV);
	COV_RAND_READ: cover property (
		rd_valid && op_q == OP_READ_RAND);
	COV_SEQ_READ: cover property (
		state_q == S_TXACK && sym_done && !sbit_q);
endmodule : isp_programmer

// [tb/eeprom_port_model.sv]
// behavioural serial configuration memory answering the programmer
// assumes the bench resolves the pulled-up data line from both drivers
`timescale 1ns/10ps
module eeprom_port_model #(
	parameter logic [6:0] DEV_ID7 = 7'h2A, // device address, arbitrary
	parameter int T_WR = 3000 // write cycle length in clk_sys cycles
) (
	input wire logic clk_sys, // oversampling clock
	input wire logic serial_clock_line, // clock from the programmer
	input wire logic serial_data_line, // resolved data line
	input wire logic program_mode_select_n, // low selects programming
	output logic sda_low, // high pulls data low
	output logic [8:0] wr_count, // data bytes of the current write
	output logic busy // internal write cycle running
);
	logic [7:0] mem [0:131071];
	logic [7:0] sh, rb;
	logic [23:0] a;
	logic [16:0] cur = 17'h00000, lastw;
	logic scl_p = 1'b1, sda_p = 1'b1, rw, mack, wrote = 1'b0;
	logic [3:0] bit_n = 4'h0;
	int st = 0, t = 0;
	wire logic c = serial_clock_line;
	wire logic d = serial_data_line;
	function automatic logic [7:0] pat(input logic [16:0] x);
		return x[7:0] ^ x[16:9] ^ 8'hC3;
	endfunction : pat
	// preload a pattern so reads of untouched places are predictable
	initial begin
		sda_low = 1'b0;
		busy = 1'b0;
		wr_count = 9'h000;
		for (int i = 0; i < 131072; i++) mem[i] = pat(17'(i));
	end
	// sampled on the falling clk_sys edge so the host never races it
	always @(negedge clk_sys) begin
		if (program_mode_select_n || t > 0) begin
			sda_low = 1'b0;
			st = 0;
			t = (t > 0) ? t - 1 : 0;
		end else if (scl_p && c && sda_p && !d) begin
			st = 1;
			bit_n = 4'hF; // the start symbol ends on a falling clock
			sda_low = 1'b0;
		end else if (scl_p && c && !sda_p && d) begin
			if (wrote) begin
				t = T_WR;
				cur = lastw + 17'h00001;
			end
			wrote = 1'b0;
			st = 0;
			sda_low = 1'b0;
		end else if (st != 0 && !scl_p && c) begin
			mack = !d;
			sh = (st == 5) ? {d, sh[7:1]} : {sh[6:0], d};
		end else if (st != 0 && scl_p && !c) begin
			if (bit_n == 4'hF) begin
				bit_n = 4'h0;
			end else if (bit_n == 4'h8) begin
				bit_n = 4'h0;
				sda_low = 1'b0;
				if (st == 1 && rw) st = 6;
				else if (st == 6 && !mack) st = 0;
				else if (st < 5) st++;
				if (st == 6) begin
					rb = mem[cur];
					sda_low = !rb[0];
				end
			end else begin
				bit_n++;
				if (bit_n < 4'h8 && st == 6) sda_low = !rb[bit_n];
				else if (bit_n == 4'h8) begin
					case (st)
						1: begin
							rw = sh[0];
							sda_low = (sh[7:1] == DEV_ID7);
							if (sh[7:1] != DEV_ID7) st = 0;
							wr_count = 9'h000;
						end
						2, 3, 4: begin
							a = {a[15:0], sh};
							sda_low = 1'b1;
						end
						5: begin
							mem[cur] = sh;
							lastw = cur;
							cur[6:0] = cur[6:0] + 7'h01;
							wr_count = wr_count + 9'h001;
							wrote = 1'b1;
							sda_low = 1'b1;
						end
						default: cur = cur + 17'h00001;
					endcase
					if (st == 4) cur = a[16:0];
				end
			end
		end
		busy = (t > 0);
		scl_p = c;
		sda_p = d;
	end
endmodule : eeprom_port_model

// [tb/config_eeprom_serial_program_port_tb_top.sv]
// self-checking bench for the serial configuration memory programmer
// assumes isp_pkg, serial_bit_engine and isp_programmer compiled first
`timescale 1ns/10ps
module config_eeprom_serial_program_port_tb_top;
	import isp_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, program_enable = 1'b0;
	logic cmd_valid = 1'b0, wr_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [23:0] cmd_addr = 24'h000000;
	logic [17:0] cmd_len = 18'h00000;
	logic [7:0] wr_data = 8'h00;
	logic cmd_ready, wr_ready, rd_valid, done, error, dev_low, busy;
	logic serial_clock_line, sda_out, sda_oe_n, program_mode_select_n;
	logic [7:0] rd_data;
	logic [8:0] wr_count;
	logic [7:0] rbuf [0:7];
	int nrd, bad_count = 0, num_checks = 0;
	// open-drain data line with pull-up
	wire logic serial_data_line = ((!sda_oe_n && !sda_out) || dev_low) ?
		1'b0 : 1'b1;
	isp_programmer i_isp_programmer (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.program_enable(program_enable), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.done(done), .error(error), .serial_clock_line(serial_clock_line),
		.serial_data_line_in(serial_data_line),
		.serial_data_line_out(sda_out), .serial_data_line_oe_n(sda_oe_n),
		.program_mode_select_n(program_mode_select_n));
	eeprom_port_model i_eeprom_port_model (.clk_sys(clk_sys),
		.serial_clock_line(serial_clock_line),
		.serial_data_line(serial_data_line),
		.program_mode_select_n(program_mode_select_n), .sda_low(dev_low),
		.wr_count(wr_count), .busy(busy));
	always #12.5 clk_sys = ~clk_sys;
	function automatic logic [7:0] wdat(input int k);
		return 8'(k * 37 + 5);
	endfunction : wdat
	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] seen);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	// one command: hold it until taken, feed page bytes, collect reads
	task automatic do_cmd(input logic [1:0] op, input logic [23:0] ad,
		input logic [17:0] len);
		int n, wk;
		n = 0;
		wk = 0;
		nrd = 0;
		cmd_op = op;
		cmd_addr = ad;
		cmd_len = len;
		cmd_valid = 1'b1;
		wr_valid = (op == OP_WRITE);
		wr_data = wdat(0);
		while (n < 30000) begin
			@(posedge clk_sys);
			if (cmd_valid && cmd_ready) n = n + 0;
			if (wr_valid && wr_ready) wk++;
			if (rd_valid && nrd < 8) begin
				rbuf[nrd] = rd_data;
				nrd++;
			end
			if (done === 1'b1) break;
			n++;
			@(negedge clk_sys);
			if (!cmd_ready) cmd_valid = 1'b0;
			wr_data = wdat(wk);
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		wr_valid = 1'b0;
		check("command finished", 24'h0, (n < 30000) ? 24'h0 : 24'h1);
	endtask : do_cmd
	task automatic t_mode();
		repeat (5) @(negedge clk_sys);
		check("select before enable", 24'h1, program_mode_select_n);
		check("ready before enable", 24'h0, cmd_ready);
		program_enable = 1'b1;
		repeat (4) @(negedge clk_sys);
		check("select after enable", 24'h0, program_mode_select_n);
		check("ready after enable", 24'h1, cmd_ready);
		check("clock idle", 24'h1, serial_clock_line);
		$display("test mode done");
	endtask : t_mode
	// page write from offset 5 so the address wraps inside the page
	task automatic t_write();
		do_cmd(OP_WRITE, 24'h000105, 18'h00000);
		check("write error", 24'h0, error);
		check("page bytes", 24'd128, wr_count);
		check("first byte", wdat(0), i_eeprom_port_model.mem[17'h105]);
		check("page end", wdat(122), i_eeprom_port_model.mem[17'h17F]);
		check("wrapped", wdat(123), i_eeprom_port_model.mem[17'h100]);
		check("last", wdat(127), i_eeprom_port_model.mem[17'h104]);
		check("next page", i_eeprom_port_model.pat(17'h180),
			i_eeprom_port_model.mem[17'h180]);
		check("write cycle", 24'h1, busy);
		$display("test write done");
	endtask : t_write
	// second page at once: the memory is busy, so the host must poll
	task automatic t_poll();
		do_cmd(OP_WRITE, 24'h000200, 18'h00000);
		check("poll error", 24'h0, error);
		check("poll bytes", 24'd128, wr_count);
		check("poll first", wdat(0), i_eeprom_port_model.mem[17'h200]);
		check("poll last", wdat(127), i_eeprom_port_model.mem[17'h27F]);
		check("poll cycle", 24'h1, busy);
		$display("test poll done");
	endtask : t_poll
	// a read during the write cycle is refused, then succeeds later
	task automatic t_refused();
		int w;
		do_cmd(OP_READ_CUR, 24'h000000, 18'h00001);
		check("refused error", 24'h1, error);
		check("refused bytes", 24'h0, nrd);
		w = 0;
		while (busy && w < 5000) begin
			@(negedge clk_sys);
			w++;
		end
		do_cmd(OP_READ_CUR, 24'h000000, 18'h00001);
		check("current error", 24'h0, error);
		check("current count", 24'h1, nrd);
		check("current byte", i_eeprom_port_model.pat(17'h280),
			rbuf[0]);
		$display("test refused done");
	endtask : t_refused
	// random read across the top of the array, then where it left off
	task automatic t_seq();
		do_cmd(OP_READ_RAND, 24'h01FFFE, 18'h00004);
		check("seq count", 24'h4, nrd);
		for (int i = 0; i < 4; i++) begin
			check("seq byte", i_eeprom_port_model.pat(17'h1FFFE + 17'(i)),
				rbuf[i]);
		end
		do_cmd(OP_READ_CUR, 24'h000000, 18'h00001);
		check("after seq", i_eeprom_port_model.pat(17'h00002), rbuf[0]);
		$display("test sequential done");
	endtask : t_seq
	initial begin
		repeat (12) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_mode();
		t_write();
		t_poll();
		t_refused();
		t_seq();
		finish_test();
	end
	// watchdog sized for two page writes, the polls and the short reads
	initial begin
		repeat (80000) @(posedge clk_sys);
		bad_count++;
		finish_test();
	end
endmodule : config_eeprom_serial_program_port_tb_top
